// File: include/cab_pkg.sv
/*
  Constants, register map and carrier types for the comma alignment block.
  Assumes a single 20 MHz clock and a 20-bit raw receive word per cycle.
*/
package cab_pkg;
  localparam int SYM_W = 10;
  localparam int WORD_W = 20;
  localparam int OFF_W = 5;
  localparam logic [4:0] OFF_MAX = 5'h13;
  localparam logic [4:0] OFF_HALF = 5'h0A;
  localparam logic [4:0] OFF_RESET = 5'h00;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PLUS = 8'h04;
  localparam logic [7:0] ADDR_MINUS = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  localparam int CTRL_DET_BIT = 0;
  localparam int CTRL_VALID_BIT = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_BYPASS_BIT = 4;
  localparam int STAT_ALIGNED_BIT = 0;
  localparam int STAT_CLKSRC_BIT = 1;
  localparam int STAT_PHASE_BIT = 2;
  localparam int STAT_OFF_LSB = 4;

  localparam logic [4:0] CTRL_RESET = 5'h01;
  localparam logic [9:0] PLUS_RESET = 10'h17C;
  localparam logic [9:0] MINUS_RESET = 10'h283;
  localparam logic [9:0] MASK_RESET = 10'h07F;

  localparam logic [6:0] COMMA_POS_BITS = 7'h7C;
  localparam logic [6:0] COMMA_NEG_BITS = 7'h03;
  localparam logic [5:0] K28_POS = 6'h3C;
  localparam logic [5:0] K28_NEG = 6'h03;
  localparam logic [9:0] K23_7_A = 10'h057;
  localparam logic [9:0] K23_7_B = 10'h3A8;
  localparam logic [9:0] K27_7_A = 10'h05B;
  localparam logic [9:0] K27_7_B = 10'h3A4;
  localparam logic [9:0] K29_7_A = 10'h05D;
  localparam logic [9:0] K29_7_B = 10'h3A2;
  localparam logic [9:0] K30_7_A = 10'h05E;
  localparam logic [9:0] K30_7_B = 10'h3A1;

  typedef enum logic [1:0] {CAB_ANY_BYTE, CAB_TWO_BYTE, CAB_FOUR_BYTE, CAB_MODE_RSVD} cab_mode_t;

  typedef struct packed {
    logic [19:0] data;
    logic [1:0] commaFlag;
    logic [1:0] controlFlag;
  } cab_rx_word_t;

  typedef struct packed {
    logic [15:0] data;
    logic [1:0] codeSkip;
    logic [1:0] dispMode;
    logic [1:0] dispValue;
  } cab_tx_word_t;
endpackage

// File: design/cab_comma_align.sv
/*
  Receive comma search, byte alignment, per-byte control flags and the
  transmit per-byte coding controls, with an Avalon-MM register slave.
  Assumes the raw receive word and fabric controls are synchronous to clk.
*/
// Chosen here: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
// Overview of operation
// [R1] Comma search only when detection enabled.
// [R2] Valid-only option accepts only legal commas.
// [R3] Match plus pattern, rightmost bit first.
// [R4] Match minus pattern, same bit order.
// [R5] Mask bits select compared pattern bits.
// [R6] Any-byte mode aligns to nearest byte.
// [R7] Two-byte mode aligns to 2-byte boundary.
// [R8] Four-byte mode aligns to 4-byte boundary.
// [R9] Plus realign only with plus enable.
// [R10] Minus realign only with minus enable.
// [R11] Each slip moves one bit, overrides commas.
// [R12] Aligned flag high while on boundaries.
// [R13] Realigned flag when comma changes alignment.
// [R14] Comma seen flag on any detection.
// [R15] Per-byte encoder bypass, upper bit upper.
// [R16] Per-byte disparity mode and value.
// [R17] Per-byte comma flag output.
// [R18] Per-byte control character flag output.
// [R19] Separate transmit and receive coding resets.
// [R20] Receive clock source follows buffer bypass.
// [R21] No enables, no slip: alignment held.
// [R22] Flags share the cycle of their bytes.
module cab_comma_align (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [19:0] rawRxWord,
  input wire logic align_on_positive_enable,
  input wire logic align_on_negative_enable,
  input wire logic rx_bit_slip,
  input wire logic rx_coding_reset,
  input wire logic tx_coding_reset,
  input wire logic [15:0] txData,
  input wire logic [1:0] tx_code_skip_per_byte,
  input wire logic [1:0] tx_disp_force_mode,
  input wire logic [1:0] tx_disp_force_value,
  output cab_pkg::cab_tx_word_t txToEncoder,
  output cab_pkg::cab_rx_word_t rxOut,
  output logic rx_aligned_flag,
  output logic rx_realigned_flag,
  output logic rx_comma_seen,
  output logic rxWordEven,
  output logic rxClockFromRxDerived
);
  logic [4:0] ctrl_reg;
  logic [9:0] plus_reg;
  logic [9:0] minus_reg;
  logic [9:0] mask_reg;
  logic ack_reg;
  logic [19:0] prev_reg;
  logic [4:0] off_reg;
  logic [4:0] off_next;
  logic slipPrev_reg;
  logic phase_reg;
  logic [39:0] hist;
  logic [19:0] plusHit;
  logic [19:0] minusHit;
  logic [19:0] useHit;
  logic found;
  logic [4:0] foundPos;
  logic slipEvent;
  logic commaDetOn;
  logic [9:0] sym0;
  logic [9:0] sym1;
  cab_pkg::cab_mode_t mode;

  function automatic logic isControl(input logic [9:0] s);
    isControl = (s[5:0] == cab_pkg::K28_POS) || (s[5:0] == cab_pkg::K28_NEG)
      || (s == cab_pkg::K23_7_A) || (s == cab_pkg::K23_7_B)
      || (s == cab_pkg::K27_7_A) || (s == cab_pkg::K27_7_B)
      || (s == cab_pkg::K29_7_A) || (s == cab_pkg::K29_7_B)
      || (s == cab_pkg::K30_7_A) || (s == cab_pkg::K30_7_B);
  endfunction

  function automatic logic isComma(input logic [9:0] s);
    isComma = isControl(s) && ((s[6:0] == cab_pkg::COMMA_POS_BITS)
      || (s[6:0] == cab_pkg::COMMA_NEG_BITS));
  endfunction

  assign commaDetOn = ctrl_reg[cab_pkg::CTRL_DET_BIT];
  assign mode = cab_cab_mode(ctrl_reg[cab_pkg::CTRL_MODE_LSB +: 2]);

  function automatic cab_pkg::cab_mode_t cab_cab_mode(input logic [1:0] m);
    unique case (m)
      2'h0: cab_cab_mode = cab_pkg::CAB_ANY_BYTE;
      2'h1: cab_cab_mode = cab_pkg::CAB_TWO_BYTE;
      2'h2: cab_cab_mode = cab_pkg::CAB_FOUR_BYTE;
      default: cab_cab_mode = cab_pkg::CAB_ANY_BYTE;
    endcase
  endfunction

  // Avalon-MM slave: every access completes one cycle after it is raised.
  // A write lands at the edge where waitrequest is low, as the master expects.
  assign waitrequest = (read || write) && !ack_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ack_reg <= 1'b0;
    else
      ack_reg <= (read || write) && !ack_reg;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl_reg <= cab_pkg::CTRL_RESET;
      plus_reg <= cab_pkg::PLUS_RESET;
      minus_reg <= cab_pkg::MINUS_RESET;
      mask_reg <= cab_pkg::MASK_RESET;
    end
    else if (write && ack_reg)
    begin
      unique case (address)
        cab_pkg::ADDR_CTRL: ctrl_reg <= writedata[4:0];
        cab_pkg::ADDR_PLUS: plus_reg <= writedata[9:0];
        cab_pkg::ADDR_MINUS: minus_reg <= writedata[9:0];
        cab_pkg::ADDR_MASK: mask_reg <= writedata[9:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      readdata <= 32'h00000000;
    else if (read && !ack_reg)
    begin
      unique case (address)
        cab_pkg::ADDR_CTRL: readdata <= {27'h0000000, ctrl_reg};
        cab_pkg::ADDR_PLUS: readdata <= {22'h000000, plus_reg};
        cab_pkg::ADDR_MINUS: readdata <= {22'h000000, minus_reg};
        cab_pkg::ADDR_MASK: readdata <= {22'h000000, mask_reg};
        cab_pkg::ADDR_STATUS: readdata <= {23'h000000, off_reg, 1'b0, phase_reg,
          rxClockFromRxDerived, rx_aligned_flag};
        default: readdata <= 32'h00000000;
      endcase
    end
  end

  // With the receive buffer bypassed the fabric clock must come from the
  // receive-derived clock; otherwise the transmit-derived clock is used.
  assign rxClockFromRxDerived = ctrl_reg[cab_pkg::CTRL_BYPASS_BIT]; // see [R20]

  // The older word sits in the low half so that bit 0 is the earliest bit.
  assign hist = {rawRxWord, prev_reg};

  for (genvar k = 0; k < 20; k++)
  begin : g_search
    logic [9:0] win;
    assign win = hist[k +: 10];
    assign plusHit[k] = ((win ^ plus_reg) & mask_reg) == 10'h000; // see [R3] see [R5]
    assign minusHit[k] = ((win ^ minus_reg) & mask_reg) == 10'h000; // see [R4] see [R5]
    assign useHit[k] = commaDetOn && (plusHit[k] || minusHit[k]) // see [R1]
      && (!ctrl_reg[cab_pkg::CTRL_VALID_BIT] || isComma(win)); // see [R2]
  end

  // The earliest matching position wins.
  always_comb
  begin
    found = 1'b0;
    foundPos = 5'h00;
    for (int i = 19; i >= 0; i--)
    begin
      if (useHit[i])
      begin
        found = 1'b1;
        foundPos = i[4:0];
      end
    end
  end

  logic foundPlus;
  logic foundMinus;
  logic mayAlign;
  assign foundPlus = found && plusHit[foundPos];
  assign foundMinus = found && minusHit[foundPos];
  assign mayAlign = (foundPlus && align_on_positive_enable) // see [R9]
    || (foundMinus && align_on_negative_enable); // see [R10]
  assign slipEvent = rx_bit_slip && !slipPrev_reg;

  always_comb
  begin
    off_next = off_reg;
    if (slipEvent)
      off_next = (off_reg == cab_pkg::OFF_MAX) ? 5'h00 : off_reg + 5'h01; // see [R11]
    else if (mayAlign)
    begin
      unique case (mode)
        cab_pkg::CAB_ANY_BYTE: // see [R6]
          off_next = (foundPos >= cab_pkg::OFF_HALF) ? foundPos - cab_pkg::OFF_HALF : foundPos;
        cab_pkg::CAB_TWO_BYTE: off_next = foundPos; // see [R7]
        cab_pkg::CAB_FOUR_BYTE: off_next = foundPos; // see [R8]
        default: off_next = foundPos;
      endcase
      // Any-byte mode already on a byte boundary keeps its offset.
      if (mode == cab_pkg::CAB_ANY_BYTE && (foundPos == off_reg
          || foundPos == off_reg + cab_pkg::OFF_HALF))
        off_next = off_reg;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || rx_coding_reset) // see [R19]
    begin
      prev_reg <= 20'h00000;
      slipPrev_reg <= 1'b0;
      off_reg <= cab_pkg::OFF_RESET;
    end
    else
    begin
      prev_reg <= rawRxWord;
      slipPrev_reg <= rx_bit_slip;
      off_reg <= off_next; // see [R21]
    end
  end

  // Four-byte alignment marks the comma word as the even half of a pair.
  always_ff @(posedge clk)
  begin
    if (!rst_n || rx_coding_reset)
      phase_reg <= 1'b0;
    else if (mayAlign && !slipEvent && mode == cab_pkg::CAB_FOUR_BYTE)
      phase_reg <= 1'b1; // see [R8]
    else
      phase_reg <= !phase_reg;
  end
  assign rxWordEven = phase_reg;

  always_ff @(posedge clk)
  begin
    if (!rst_n || rx_coding_reset)
    begin
      rx_aligned_flag <= 1'b0;
      rx_realigned_flag <= 1'b0;
      rx_comma_seen <= 1'b0;
    end
    else
    begin
      rx_comma_seen <= found; // see [R14]
      rx_realigned_flag <= !slipEvent && mayAlign && (off_next != off_reg); // see [R13]
      if (slipEvent || !commaDetOn)
        rx_aligned_flag <= 1'b0;
      else if (mayAlign)
        rx_aligned_flag <= 1'b1; // see [R12]
    end
  end

  assign sym0 = hist[off_reg +: 10];
  assign sym1 = hist[(off_reg + 5'h0A) +: 10];

  always_ff @(posedge clk)
  begin
    if (!rst_n || rx_coding_reset)
      rxOut <= '0;
    else
    begin
      rxOut.data <= {sym1, sym0}; // see [R22]
      rxOut.commaFlag <= {isComma(sym1), isComma(sym0)}; // see [R17]
      rxOut.controlFlag <= {isControl(sym1), isControl(sym0)}; // see [R18]
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || tx_coding_reset) // see [R19]
      txToEncoder <= '0;
    else
    begin
      txToEncoder.data <= txData;
      txToEncoder.codeSkip <= tx_code_skip_per_byte; // see [R15]
      txToEncoder.dispMode <= tx_disp_force_mode; // see [R16]
      txToEncoder.dispValue <= tx_disp_force_value; // see [R16]
    end
  end

  chk_slip_one_bit: assert property (@(posedge clk) disable iff (!rst_n || rx_coding_reset) // see [R11]
    slipEvent |=> off_reg == (($past(off_reg) == cab_pkg::OFF_MAX) ? 5'h00 : $past(off_reg) + 5'h01))
    else $error("slip did not move alignment by one bit");
  chk_hold_no_enable: assert property (@(posedge clk) disable iff (!rst_n || rx_coding_reset) // see [R21]
    (!align_on_positive_enable && !align_on_negative_enable && !slipEvent) |=> $stable(off_reg))
    else $error("alignment moved with enables low");
  chk_detect_off: assert property (@(posedge clk) disable iff (!rst_n || rx_coding_reset) // see [R1]
    !commaDetOn |=> !rx_comma_seen && !rx_realigned_flag)
    else $error("comma activity with detection off");
  chk_realign_pulse: assert property (@(posedge clk) disable iff (!rst_n || rx_coding_reset) // see [R13]
    rx_realigned_flag |-> rx_aligned_flag && off_reg != $past(off_reg))
    else $error("realigned flag without alignment change");
  chk_slip_clears: assert property (@(posedge clk) disable iff (!rst_n || rx_coding_reset) // see [R12]
    slipEvent |=> !rx_aligned_flag && !rx_realigned_flag)
    else $error("aligned flag survived a slip");
  chk_two_byte_pos: assert property (@(posedge clk) disable iff (!rst_n || rx_coding_reset) // see [R7]
    (mayAlign && !slipEvent && mode == cab_pkg::CAB_TWO_BYTE) |=> off_reg == $past(foundPos))
    else $error("two-byte alignment offset wrong");
  chk_any_byte_pos: assert property (@(posedge clk) disable iff (!rst_n || rx_coding_reset) // see [R6]
    (mayAlign && !slipEvent && mode == cab_pkg::CAB_ANY_BYTE)
      |=> off_reg == $past(foundPos) || off_reg + cab_pkg::OFF_HALF == $past(foundPos))
    else $error("any-byte alignment not on a byte boundary");
  chk_flag_timing: assert property (@(posedge clk) disable iff (!rst_n || rx_coding_reset) // see [R22]
    1'b1 |=> rxOut.controlFlag[0] == isControl($past(sym0)) && rxOut.data[9:0] == $past(sym0))
    else $error("flags not in step with data");
  chk_tx_controls: assert property (@(posedge clk) disable iff (!rst_n || tx_coding_reset) // see [R15]
    1'b1 |=> txToEncoder.codeSkip == $past(tx_code_skip_per_byte)
      && txToEncoder.dispMode == $past(tx_disp_force_mode))
    else $error("transmit per-byte controls lost");
endmodule

// File: dv/cab_serial_src.sv
/*
  Serial source model: two 10-bit symbols per cycle, bit 0 sent first.
  Assumes the bench changes phase only while no comma is being sent.
*/
`timescale 1ns/1ps
module cab_serial_src (
  input wire logic clk,
  input wire logic [3:0] phase,
  input wire logic sendPlus,
  input wire logic sendMinus,
  input wire logic upper,
  output logic [19:0] rawRxWord
);
  logic [19:0] tail = 20'h00000;
  logic [9:0] sym;
  logic [19:0] pair;
  always_comb
  begin
    sym = sendMinus ? 10'h283 : 10'h17C;
    pair = {10'h2AA, 10'h2AA};
    if (sendPlus || sendMinus)
      pair = upper ? {sym, 10'h2AA} : {10'h2AA, sym};
  end
  // Bits shifted past the word boundary carry into the next word.
  always_ff @(posedge clk)
  begin
    rawRxWord <= (pair << phase) | tail;
    tail <= pair >> (5'd20 - 5'(phase));
  end
endmodule

// File: dv/cab_comma_align_tb.sv
/*
  Testbench for the comma alignment block: registers, receive and transmit paths.
  Assumes the serial source model and a 50 ns clock.
*/
`timescale 1ns/1ps
module cab_comma_align_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [19:0] rawRxWord;
  logic posEn = 1'b0;
  logic negEn = 1'b0;
  logic slip = 1'b0;
  logic txRst = 1'b0;
  logic rxRst = 1'b0;
  logic [15:0] txData = 16'h0000;
  logic [1:0] skip = 2'h0, dMode = 2'h0, dVal = 2'h0;
  cab_pkg::cab_tx_word_t txOut;
  cab_pkg::cab_rx_word_t rxOut, lastRx;
  logic aligned, realigned, seen;
  logic even, clkSrc;
  logic evenSeen = 1'b0;
  logic [3:0] phase = 4'h0;
  logic sendPlus = 1'b0, sendMinus = 1'b0, upper = 1'b0;
  int err_total = 0, n_tests = 0, seenCnt = 0, realCnt = 0, cycles = 0;
  logic [31:0] q;
  int m;
  always #25 clk = ~clk;
  cab_comma_align u_cab_comma_align (.clk(clk), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .rawRxWord(rawRxWord), .align_on_positive_enable(posEn),
    .align_on_negative_enable(negEn), .rx_bit_slip(slip), .rx_coding_reset(rxRst),
    .tx_coding_reset(txRst), .txData(txData), .tx_code_skip_per_byte(skip),
    .tx_disp_force_mode(dMode), .tx_disp_force_value(dVal), .txToEncoder(txOut),
    .rxOut(rxOut), .rx_aligned_flag(aligned), .rx_realigned_flag(realigned),
    .rx_comma_seen(seen), .rxWordEven(even), .rxClockFromRxDerived(clkSrc));
  cab_serial_src u_cab_serial_src (.clk(clk), .phase(phase), .sendPlus(sendPlus),
    .sendMinus(sendMinus), .upper(upper), .rawRxWord(rawRxWord));
  task automatic results();
    if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (seen === 1'b1)
      seenCnt++;
    if (realigned === 1'b1)
    begin
      realCnt++;
      evenSeen = even;
    end
    if (rxOut.commaFlag !== 2'h0)
      lastRx = rxOut;
    if (cycles == 4000)
    begin
      err_total++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Holds the request until waitrequest is sampled low; one edge passes before the next.
  task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] d);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= d;
    do
      @(posedge clk);
    while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e);
    av(1'b0, a, 32'h0);
    chk(q & msk, e);
  endtask
  task automatic send(input logic [3:0] p, input logic neg, input logic up);
    phase <= p;
    upper <= up;
    repeat (3) @(posedge clk);
    seenCnt = 0;
    realCnt = 0;
    sendPlus <= !neg;
    sendMinus <= neg;
    @(posedge clk);
    sendPlus <= 1'b0;
    sendMinus <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(8'h00, 32'hFFFFFFFF, 32'h01);
    rd(8'h04, 32'hFFFFFFFF, 32'h17C);
    rd(8'h08, 32'hFFFFFFFF, 32'h283);
    rd(8'h0C, 32'hFFFFFFFF, 32'h07F);
    rd(8'h14, 32'hFFFFFFFF, 32'h0);
    chk(32'(clkSrc), 32'h0);
    send(4'h3, 1'b0, 1'b0);
    chk(32'(seenCnt > 0), 32'h1);
    chk(32'(realCnt), 32'h0);
    rd(8'h10, 32'h1F1, 32'h0);
    posEn <= 1'b1;
    send(4'h4, 1'b1, 1'b0);
    chk(32'(realCnt), 32'h0);
    // Four-byte, two-byte, then any-byte mode, each at a new bit phase.
    for (m = 2; m >= 0; m--)
    begin
      av(1'b1, 8'h00, 32'(1 + 4 * m));
      send(4'(2 + 3 * m), 1'b0, 1'b0);
      chk(32'(realCnt > 0), 32'h1);
      rd(8'h10, 32'h1F1, 32'((2 + 3 * m) * 16 + 1));
      if (m == 2)
        chk(32'(evenSeen), 32'h1);
    end
    send(4'h2, 1'b0, 1'b1);
    chk(32'(lastRx), 32'({10'h17C, 10'h2AA, 4'hA}));
    send(4'h2, 1'b0, 1'b0);
    chk(32'(lastRx), 32'({10'h2AA, 10'h17C, 4'h5}));
    posEn <= 1'b0;
    negEn <= 1'b1;
    send(4'h6, 1'b1, 1'b0);
    rd(8'h10, 32'h1F1, 32'h61);
    chk(32'(aligned), 32'h1);
    slip <= 1'b1;
    @(posedge clk);
    slip <= 1'b0;
    repeat (4) @(posedge clk);
    rd(8'h10, 32'h1F1, 32'h70);
    chk(32'(aligned), 32'h0);
    rxRst <= 1'b1;
    @(posedge clk);
    rxRst <= 1'b0;
    rd(8'h10, 32'h1F1, 32'h0);
    // With the mask cleared every window matches, so only the valid-only filter limits hits.
    negEn <= 1'b0;
    av(1'b1, 8'h0C, 32'h0);
    av(1'b1, 8'h00, 32'h3);
    send(4'h1, 1'b0, 1'b0);
    chk(32'(seenCnt), 32'h1);
    av(1'b1, 8'h00, 32'h10);
    chk(32'(clkSrc), 32'h1);
    send(4'h1, 1'b0, 1'b0);
    chk(32'(seenCnt), 32'h0);
    rd(8'h10, 32'h2, 32'h2);
    txData <= 16'hA55A;
    skip <= 2'h2;
    dMode <= 2'h1;
    dVal <= 2'h3;
    @(posedge clk);
    @(negedge clk);
    chk(32'(txOut), 32'({16'hA55A, 2'h2, 2'h1, 2'h3}));
    @(posedge clk);
    txRst <= 1'b1;
    @(posedge clk);
    txRst <= 1'b0;
    @(negedge clk);
    chk(32'(txOut), 32'h0);
    results();
  end
endmodule
